// >>> common/ext_bus_pins_pkg.sv
// constants and types for the external bus pin-function block
package ext_bus_pins_pkg;

  localparam int unsigned NUM_AREAS = 7;
  localparam int unsigned NUM_LANES = 4;
  localparam int unsigned TYPE_W = 3;

  // memory interface type of an area
  typedef enum logic [2:0] {
    IF_SRAM = 3'h0,
    IF_DRAM = 3'h1,
    IF_SDRAM = 3'h2,
    IF_MUXED = 3'h3,
    IF_CARD = 3'h4,
    IF_BROM = 3'h5
  } if_type_e;

  // bus cycle sequencer, gray along idle-addr-data-done
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_DATA = 2'b11,
    ST_LAST = 2'b10
  } cyc_state_e;

  // reset values and the beat counter width
  localparam logic [6:0] SEL_IDLE = 7'h7F;
  localparam logic [3:0] LANE_IDLE = 4'hF;
  localparam logic [1:0] WIDTH_RST = 2'h0;
  localparam logic [3:0] BEAT_RST = 4'h0;
  localparam int unsigned BEAT_W = 4;

endpackage : ext_bus_pins_pkg

// >>> rtl/strap_latch.sv
// catches power-on mode straps once at reset release and holds them
`timescale 1ns/100ps
module strap_latch #(
  parameter int unsigned WIDTH = 5
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // strap levels
  input wire logic [WIDTH-1:0] strap_i,
  // held settings
  output logic [WIDTH-1:0] strap_o,
  output logic valid_o
);

  typedef struct packed {
    logic [WIDTH-1:0] val;
    logic done;
  } strap_s;

  strap_s st_r;
  strap_s st_nxt;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("strap_latch: WIDTH must be at least 1");
  end

  always_comb
  begin
    st_nxt = st_r;
    // first clocked edge after release captures; later pin reuse is ignored
    if (!st_r.done)
    begin
      st_nxt.val = strap_i;
      st_nxt.done = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign strap_o = st_r.val;
  assign valid_o = st_r.done;

endmodule // strap_latch

// >>> rtl/external_bus_controller.sv
// external bus pin-function and signal-role logic
//
// Overview of operation
// - sdram or muxed area: bus-cycle-start pulses once for a whole burst
// - other interface bursts: bus-cycle-start pulses once per data beat
// - seven active-low area selects, one per external area
// - card mode: area five and six selects act as card low enables
// - read/write sets data direction; write indication for dram, sdram, card
// - shared read pin: read strobe, sdram column strobe, muxed frame
// - sram: four byte write strobes, lane zero up to lane three
// - card: lanes become attribute select, write, io read, io write
// - dram: four per-lane column address strobes
// - sdram: the same four pins act as per-lane data masks
// - ready high requests waits; the cycle stretches while it is held
// - at power-on, mode pin high selects sram, low muxed for area zero
// - card mode: same pin is 16-bit io flag, only in little endian
// - drive the sdram clock enable output
// - release request input answered by grant output; no role swap in slave
// - two straps give area zero width; card mode reuses them as high enables
// - high card enable pins are inputs unless areas five/six card bit set
// - endian strap sampled at power-on decides external byte order
// - master/slave strap sampled at power-on, then serial clear-to-send
// - two dma data acknowledges, one per channel zero and one
// - exactly the select of the accessed area, zero to six, asserts
// - card access to five/six also asserts high enables per byte
`timescale 1ns/100ps
module external_bus_controller #(
  parameter int unsigned BURST_MAX = 8
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // access request from the core side
  input wire logic acc_req_i,
  input wire logic [2:0] acc_area_i,
  input wire logic acc_write_i,
  input wire logic [3:0] acc_lanes_i,
  input wire logic [3:0] acc_beats_i,
  input wire logic acc_io_i,
  output logic acc_ack_o,
  output logic acc_done_o,
  // per-area interface types, card control and sdram clock run
  input wire logic [20:0] area_type_i,
  input wire logic areas56_card_mode_bit_i,
  input wire logic sdram_clk_run_i,
  // dma acknowledge requests
  input wire logic [1:0] dma_ack_req_i,
  // strap and shared pins
  input wire logic area0_muxsel_io16_i,
  input wire logic endian_strap_i,
  input wire logic master_slave_strap_i,
  input wire logic width_cfg_card_en_a_i,
  input wire logic width_cfg_card_en_b_i,
  output logic width_cfg_card_en_a_o,
  output logic width_cfg_card_en_b_o,
  output logic width_cfg_card_en_a_oe_o,
  output logic width_cfg_card_en_b_oe_o,
  // bus control pins
  output logic bus_cycle_start_n_o,
  output logic [6:0] area_select_n_o,
  output logic read_write_o,
  output logic read_strobe_shared_n_o,
  output logic lane0_write_strobe_n_o,
  output logic lane1_write_strobe_n_o,
  output logic lane2_write_strobe_n_o,
  output logic lane3_write_strobe_n_o,
  output logic [3:0] lane_column_mask_n_o,
  output logic sdram_clk_en_o,
  input wire logic ready_n_i,
  // bus arbitration
  input wire logic bus_release_req_in_n_i,
  output logic bus_grant_out_n_o,
  // dma acknowledges
  output logic dma_ch0_ack_o,
  output logic dma_ch1_ack_o,
  // held strap settings, then cts and io16 flag from live pins
  output logic area0_sram_o,
  output logic [1:0] area0_width_o,
  output logic little_endian_o,
  output logic bus_master_o,
  output logic serial_cts_o,
  output logic card_io16_o
);

  typedef struct packed {
    ext_bus_pins_pkg::cyc_state_e st;
    logic [2:0] area;
    logic write;
    logic [3:0] lanes;
    logic [3:0] beats;
    logic io;
    logic cyc_start_n;
    logic [6:0] sel_n;
    logic rw;
    logic rd_n;
    logic [3:0] we_n;
    logic [3:0] cas_n;
    logic ce2a_n;
    logic ce2b_n;
    logic cke;
    logic grant_n;
    logic [1:0] dack;
    logic ack;
    logic done;
  } ctl_s;

  ctl_s c_r;
  ctl_s c_nxt;

  logic [4:0] strap_raw;
  logic [4:0] strap_held;
  logic strap_valid;
  ext_bus_pins_pkg::if_type_e cur_type;
  logic card_area;
  logic sdram_like;

  // beat counter is four bits wide
  if (BURST_MAX < 1 || BURST_MAX > 15)
  begin : g_bad_burst
    $error("external_bus_controller: BURST_MAX must be 1..15");
  end

  assign strap_raw = {master_slave_strap_i, endian_strap_i, width_cfg_card_en_b_i,
                      width_cfg_card_en_a_i, area0_muxsel_io16_i};

  strap_latch #(
    .WIDTH(5)
  ) u_straps (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .strap_i(strap_raw),
    .strap_o(strap_held),
    .valid_o(strap_valid)
  );

  assign area0_sram_o = strap_held[0];
  assign area0_width_o = strap_held[2:1];
  assign little_endian_o = strap_held[3];
  assign bus_master_o = strap_held[4];
  assign serial_cts_o = master_slave_strap_i;
  // io16 honoured in little endian only
  assign card_io16_o = areas56_card_mode_bit_i & strap_held[3] & area0_muxsel_io16_i;

  // area type lookup; area zero follows its strap
  always_comb
  begin
    cur_type = ext_bus_pins_pkg::IF_SRAM;
    if (c_r.area == 3'h0)
    begin
      cur_type = strap_held[0] ? ext_bus_pins_pkg::IF_SRAM : ext_bus_pins_pkg::IF_MUXED;
    end
    else if (c_r.area < 3'h7)
    begin
      cur_type = ext_bus_pins_pkg::if_type_e'(area_type_i[c_r.area*3 +: 3]);
    end
  end

  assign card_area = areas56_card_mode_bit_i &&
                     (c_r.area == 3'h5 || c_r.area == 3'h6);
  assign sdram_like = (cur_type == ext_bus_pins_pkg::IF_SDRAM) ||
                      (cur_type == ext_bus_pins_pkg::IF_MUXED);

  always_comb
  begin
    c_nxt = c_r;
    c_nxt.ack = 1'b0;
    c_nxt.done = 1'b0;
    c_nxt.dack = dma_ack_req_i;
    c_nxt.cke = sdram_clk_run_i;
    case (c_r.st)
      ext_bus_pins_pkg::ST_IDLE:
      begin
        c_nxt.cyc_start_n = 1'b1;
        c_nxt.sel_n = ext_bus_pins_pkg::SEL_IDLE;
        c_nxt.rd_n = 1'b1;
        c_nxt.rw = 1'b1;
        c_nxt.we_n = ext_bus_pins_pkg::LANE_IDLE;
        c_nxt.cas_n = ext_bus_pins_pkg::LANE_IDLE;
        c_nxt.ce2a_n = 1'b1;
        c_nxt.ce2b_n = 1'b1;
        c_nxt.grant_n = bus_release_req_in_n_i;
        if (acc_req_i && bus_release_req_in_n_i && acc_area_i < 3'h7 && strap_valid)
        begin
          c_nxt.area = acc_area_i;
          c_nxt.write = acc_write_i;
          c_nxt.lanes = acc_lanes_i;
          c_nxt.io = acc_io_i;
          c_nxt.beats = (acc_beats_i == 4'h0) ? 4'h1 :
                        (acc_beats_i > 4'(BURST_MAX)) ? 4'(BURST_MAX) : acc_beats_i;
          c_nxt.ack = 1'b1;
          c_nxt.st = ext_bus_pins_pkg::ST_ADDR;
        end
      end
      ext_bus_pins_pkg::ST_ADDR:
      begin
        // one-hot select of the target area
        c_nxt.sel_n = ~(7'h01 << c_r.area);
        c_nxt.rw = !c_r.write;
        // start marks the first data cycle in every mode
        c_nxt.cyc_start_n = 1'b0;
        c_nxt.st = ext_bus_pins_pkg::ST_DATA;
        case (cur_type)
          ext_bus_pins_pkg::IF_SDRAM:
          begin
            // column strobe; masks active low per lane
            c_nxt.rd_n = 1'b0;
            c_nxt.cas_n = ~c_r.lanes;
          end
          ext_bus_pins_pkg::IF_MUXED:
          begin
            c_nxt.rd_n = 1'b0;
          end
          ext_bus_pins_pkg::IF_DRAM:
          begin
            c_nxt.cas_n = ~c_r.lanes;
            c_nxt.rd_n = c_r.write;
          end
          default:
          begin
            c_nxt.rd_n = c_r.write;
          end
        endcase
        if (card_area)
        begin
          c_nxt.we_n[0] = c_r.io;
          c_nxt.we_n[1] = !(c_r.write && !c_r.io);
          c_nxt.we_n[2] = !(!c_r.write && c_r.io);
          c_nxt.we_n[3] = !(c_r.write && c_r.io);
          c_nxt.ce2a_n = !c_r.lanes[1];
          c_nxt.ce2b_n = !c_r.lanes[3];
        end
        else if (cur_type == ext_bus_pins_pkg::IF_SRAM ||
                 cur_type == ext_bus_pins_pkg::IF_BROM)
        begin
          c_nxt.we_n = c_r.write ? ~c_r.lanes : ext_bus_pins_pkg::LANE_IDLE;
        end
      end
      ext_bus_pins_pkg::ST_DATA:
      begin
        c_nxt.cyc_start_n = 1'b1;
        // hold the beat while ready is high
        if (!ready_n_i)
        begin
          c_nxt.beats = 4'(c_r.beats - 4'h1);
          if (c_r.beats == 4'h1)
          begin
            c_nxt.st = ext_bus_pins_pkg::ST_LAST;
          end
          // restart each beat; suppressed for sdram and muxed
          else if (!sdram_like)
          begin
            c_nxt.cyc_start_n = 1'b0;
          end
        end
      end
      ext_bus_pins_pkg::ST_LAST:
      begin
        c_nxt.cyc_start_n = 1'b1;
        c_nxt.sel_n = ext_bus_pins_pkg::SEL_IDLE;
        c_nxt.rd_n = 1'b1;
        c_nxt.rw = 1'b1;
        c_nxt.we_n = ext_bus_pins_pkg::LANE_IDLE;
        c_nxt.cas_n = ext_bus_pins_pkg::LANE_IDLE;
        c_nxt.ce2a_n = 1'b1;
        c_nxt.ce2b_n = 1'b1;
        c_nxt.done = 1'b1;
        c_nxt.st = ext_bus_pins_pkg::ST_IDLE;
      end
      default:
      begin
        c_nxt.st = ext_bus_pins_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      c_r.st <= ext_bus_pins_pkg::ST_IDLE;
      c_r.area <= 3'h0;
      c_r.write <= 1'b0;
      c_r.lanes <= 4'h0;
      c_r.beats <= ext_bus_pins_pkg::BEAT_RST;
      c_r.io <= 1'b0;
      c_r.cyc_start_n <= 1'b1;
      c_r.sel_n <= ext_bus_pins_pkg::SEL_IDLE;
      c_r.rw <= 1'b1;
      c_r.rd_n <= 1'b1;
      c_r.we_n <= ext_bus_pins_pkg::LANE_IDLE;
      c_r.cas_n <= ext_bus_pins_pkg::LANE_IDLE;
      c_r.ce2a_n <= 1'b1;
      c_r.ce2b_n <= 1'b1;
      c_r.cke <= 1'b0;
      c_r.grant_n <= 1'b1;
      c_r.dack <= 2'h0;
      c_r.ack <= 1'b0;
      c_r.done <= 1'b0;
    end
    else
    begin
      c_r <= c_nxt;
    end
  end

  assign acc_ack_o = c_r.ack;
  assign acc_done_o = c_r.done;
  assign bus_cycle_start_n_o = c_r.cyc_start_n;
  // selects five/six double as card low enables
  assign area_select_n_o = c_r.sel_n;
  assign read_write_o = c_r.rw;
  assign read_strobe_shared_n_o = c_r.rd_n;
  assign lane0_write_strobe_n_o = c_r.we_n[0];
  assign lane1_write_strobe_n_o = c_r.we_n[1];
  assign lane2_write_strobe_n_o = c_r.we_n[2];
  assign lane3_write_strobe_n_o = c_r.we_n[3];
  assign lane_column_mask_n_o = c_r.cas_n;
  assign sdram_clk_en_o = c_r.cke;
  assign bus_grant_out_n_o = c_r.grant_n;
  assign dma_ch0_ack_o = c_r.dack[0];
  assign dma_ch1_ack_o = c_r.dack[1];
  assign width_cfg_card_en_a_o = c_r.ce2a_n;
  assign width_cfg_card_en_b_o = c_r.ce2b_n;
  assign width_cfg_card_en_a_oe_o = areas56_card_mode_bit_i;
  assign width_cfg_card_en_b_oe_o = areas56_card_mode_bit_i;

endmodule // external_bus_controller

// >>> tb/ext_mem_model.sv
// far-side memory model that answers with a settable number of wait cycles
`timescale 1ns/100ps
module ext_mem_model (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // bus side
  input wire logic [6:0] area_select_n_i,
  input wire logic [3:0] waits_i,
  output logic ready_n_o
);
  logic [3:0] wait_r;
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      wait_r <= 4'h0;
    else if (&area_select_n_i)
      wait_r <= waits_i;
    else if (wait_r != 4'h0)
      wait_r <= wait_r - 4'h1;
  end
  assign ready_n_o = (wait_r != 4'h0);
endmodule // ext_mem_model

// >>> tb/external_bus_controller_asserts.sv
// concurrent checks on the external bus pin-function block
`timescale 1ns/100ps
module external_bus_controller_asserts (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // watched ports
  input wire logic acc_ack_o,
  input wire logic acc_done_o,
  input wire logic ready_n_i,
  input wire logic [6:0] area_select_n_o,
  input wire logic bus_cycle_start_n_o,
  input wire logic bus_release_req_in_n_i,
  input wire logic bus_grant_out_n_o,
  input wire logic sdram_clk_run_i,
  input wire logic sdram_clk_en_o,
  input wire logic [1:0] dma_ack_req_i,
  input wire logic dma_ch1_ack_o,
  input wire logic areas56_card_mode_bit_i,
  input wire logic width_cfg_card_en_a_oe_o,
  input wire logic area0_muxsel_io16_i,
  input wire logic little_endian_o,
  input wire logic card_io16_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_one_area: assert property ($onehot0(~area_select_n_o))
    else $error("more than one select");
  a_start_sel: assert property (!bus_cycle_start_n_o |-> area_select_n_o != 7'h7F)
    else $error("start without select");
  a_grant_noack: assert property (!bus_grant_out_n_o |-> !acc_ack_o)
    else $error("ack while bus granted away");
  a_grant_drop: assert property (bus_release_req_in_n_i |=> bus_grant_out_n_o)
    else $error("grant kept after release");
  a_wait_hold: assert property (ready_n_i [*3] |-> !acc_done_o)
    else $error("done during waits");
  a_cke_follow: assert property ($rose(sdram_clk_run_i) |=> sdram_clk_en_o)
    else $error("clock enable late");
  a_dack_one: assert property (dma_ack_req_i[1] |=> dma_ch1_ack_o)
    else $error("dma ack one missing");
  a_card_dir: assert property (width_cfg_card_en_a_oe_o == areas56_card_mode_bit_i)
    else $error("card enable direction");
  a_io16_gate: assert property (card_io16_o ==
    (areas56_card_mode_bit_i && little_endian_o && area0_muxsel_io16_i))
    else $error("io16 flag gating");
  a_strap_held: assert property ($past(rst_b_i, 2) && $past(rst_b_i) |->
    $stable(little_endian_o))
    else $error("strap changed");
  c_wait: cover property (!bus_cycle_start_n_o && ready_n_i);
  c_done: cover property (acc_done_o);
  c_grant: cover property (!bus_grant_out_n_o);
endmodule // external_bus_controller_asserts

// >>> tb/test_external_bus_controller.sv
// self-checking bench for the external bus pin-function block
`timescale 1ns/100ps
module test_external_bus_controller;
  logic core_clk_i = 0, rst_b_i = 0, acc_req_i = 0, acc_write_i = 0, acc_io_i = 0;
  logic areas56_card_mode_bit_i = 0, sdram_clk_run_i = 0, bus_release_req_in_n_i = 1;
  logic area0_muxsel_io16_i = 1, endian_strap_i = 1, master_slave_strap_i = 1;
  logic width_cfg_card_en_a_i = 1, width_cfg_card_en_b_i = 0, ready_n_i;
  logic [2:0] acc_area_i = 3'h0;
  logic [3:0] acc_lanes_i = 4'h0, acc_beats_i = 4'h1, waits = 4'h0, ws, cm;
  logic [1:0] dma_ack_req_i = 2'h0, area0_width_o;
  logic [20:0] area_type_i = 21'h16_3280;
  logic acc_ack_o, acc_done_o, width_cfg_card_en_a_o, width_cfg_card_en_b_o;
  logic width_cfg_card_en_a_oe_o, width_cfg_card_en_b_oe_o, bus_cycle_start_n_o;
  logic read_write_o, read_strobe_shared_n_o, lane0_write_strobe_n_o, lane1_write_strobe_n_o;
  logic lane2_write_strobe_n_o, lane3_write_strobe_n_o, sdram_clk_en_o, bus_grant_out_n_o;
  logic dma_ch0_ack_o, dma_ch1_ack_o, area0_sram_o, little_endian_o, bus_master_o;
  logic serial_cts_o, card_io16_o, rsn, rwl, cea, ceb, seen;
  logic [6:0] area_select_n_o, sel;
  logic [3:0] lane_column_mask_n_o;
  int fail_count = 0, n_tests = 0, starts, dur, d0;

  external_bus_controller #(.BURST_MAX(8)) u_external_bus_controller (.*);
  ext_mem_model u_ext_mem_model (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .area_select_n_i(area_select_n_o), .waits_i(waits), .ready_n_o(ready_n_i));

  initial
  begin
    forever #4 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input logic c, input string m);
    n_tests++;
    if (c !== 1'b1)
    begin
      fail_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one access, lows of select, strobe, mask, direction and card enable pins gathered until done
  task automatic run(input logic [2:0] a, input logic w, input logic [3:0] ln, bt,
    input logic io);
    sel = 7'h7F;
    ws = 4'hF;
    cm = 4'hF;
    {rsn, rwl, cea, ceb} = 4'hF;
    starts = 0;
    dur = 0;
    @(negedge core_clk_i);
    {acc_area_i, acc_write_i, acc_lanes_i, acc_beats_i, acc_io_i} = {a, w, ln, bt, io};
    acc_req_i = 1;
    repeat (60)
    begin
      @(negedge core_clk_i);
      dur++;
      if (acc_ack_o === 1'b1)
        acc_req_i = 0;
      sel &= area_select_n_o;
      ws &= {lane3_write_strobe_n_o, lane2_write_strobe_n_o, lane1_write_strobe_n_o,
        lane0_write_strobe_n_o};
      cm &= lane_column_mask_n_o;
      rsn &= read_strobe_shared_n_o;
      rwl &= read_write_o;
      cea &= width_cfg_card_en_a_o;
      ceb &= width_cfg_card_en_b_o;
      starts += (bus_cycle_start_n_o === 1'b0);
      if (acc_done_o === 1'b1)
        break;
    end
    acc_req_i = 0;
    chk(acc_done_o, "no done");
  endtask

  task automatic t_straps;
    chk(area0_sram_o === 1'b1, "area0 type");
    chk(area0_width_o === 2'h1, "area0 width");
    chk(little_endian_o === 1'b1, "endian");
    chk(bus_master_o === 1'b1, "master");
    chk(sdram_clk_en_o === 1'b0, "cke idle");
    @(negedge core_clk_i);
    {area0_muxsel_io16_i, endian_strap_i, master_slave_strap_i} = 3'h0;
    width_cfg_card_en_a_i = 0;
    repeat (2) @(negedge core_clk_i);
    chk(serial_cts_o === 1'b0, "cts pin");
    chk({area0_sram_o, area0_width_o, little_endian_o} === 4'hB, "straps moved");
    area0_muxsel_io16_i = 1;
  endtask

  task automatic t_areas;
    for (int a = 0; a < 7; a++)
    begin
      run(a[2:0], 0, 4'hF, 4'h1, 0);
      chk(sel === ~(7'h01 << a), "select");
      chk(rwl === 1'b1, "read dir");
    end
  endtask

  task automatic t_lanes;
    run(3'h1, 1, 4'h5, 4'h1, 0);
    chk(ws === 4'hA, "sram write lanes");
    chk(rwl === 1'b0, "write dir");
    run(3'h3, 1, 4'hA, 4'h1, 0);
    chk(cm === 4'h5, "dram lanes");
    chk(rwl === 1'b0, "dram write");
    run(3'h2, 0, 4'h3, 4'h4, 0);
    chk(starts === 1, "sdram starts");
    chk(rsn === 1'b0, "column strobe");
    chk(cm === 4'hC, "sdram masks");
    run(3'h4, 0, 4'hF, 4'h4, 0);
    chk(starts === 1, "muxed starts");
    chk(rsn === 1'b0, "frame");
  endtask

  task automatic t_burst_wait;
    run(3'h1, 0, 4'hF, 4'h4, 0);
    chk(starts === 4, "burst starts");
    chk(rsn === 1'b0, "read strobe");
    d0 = dur;
    waits = 4'h3;
    run(3'h1, 0, 4'hF, 4'h4, 0);
    chk(dur > d0, "no stretch");
    waits = 4'h0;
  endtask

  task automatic t_card;
    @(negedge core_clk_i);
    areas56_card_mode_bit_i = 1;
    @(negedge core_clk_i);
    chk(width_cfg_card_en_b_oe_o === 1'b1, "card dir");
    chk(card_io16_o === 1'b1, "io16");
    run(3'h5, 1, 4'h2, 4'h1, 0);
    chk(sel === 7'h5F, "card low a");
    chk(ws === 4'hC, "card write lanes");
    chk(cea === 1'b0, "high enable a");
    run(3'h6, 0, 4'h8, 4'h1, 1);
    chk(sel === 7'h3F && ws[2] === 1'b0, "io read");
    chk(ceb === 1'b0, "high enable b");
    run(3'h6, 1, 4'h8, 4'h1, 1);
    chk(ws[3] === 1'b0, "io write");
    areas56_card_mode_bit_i = 0;
    @(negedge core_clk_i);
    chk(width_cfg_card_en_a_oe_o === 1'b0, "card dir off");
  endtask

  task automatic t_misc;
    @(negedge core_clk_i);
    sdram_clk_run_i = 1;
    dma_ack_req_i = 2'h2;
    @(negedge core_clk_i);
    chk(sdram_clk_en_o === 1'b1, "cke");
    chk({dma_ch1_ack_o, dma_ch0_ack_o} === 2'h2, "dma ack");
    bus_release_req_in_n_i = 0;
    @(negedge core_clk_i);
    chk(bus_grant_out_n_o === 1'b0, "grant");
    acc_area_i = 3'h1;
    acc_req_i = 1;
    seen = 0;
    repeat (4) @(negedge core_clk_i) seen |= (acc_ack_o === 1'b1);
    chk(seen === 1'b0, "taken while released");
    {acc_req_i, bus_release_req_in_n_i, dma_ack_req_i} = 4'h4;
    @(negedge core_clk_i);
    chk(bus_grant_out_n_o === 1'b1, "grant drop");
  endtask

  // second power-on with other straps: area zero muxed, big endian
  task automatic t_rerun;
    @(negedge core_clk_i);
    rst_b_i = 0;
    {area0_muxsel_io16_i, endian_strap_i, width_cfg_card_en_a_i, width_cfg_card_en_b_i} = 4'h1;
    repeat (2) @(negedge core_clk_i);
    rst_b_i = 1;
    repeat (2) @(negedge core_clk_i);
    chk({area0_sram_o, area0_width_o, little_endian_o, bus_master_o} === 5'h08, "restrap");
    run(3'h0, 0, 4'hF, 4'h4, 0);
    chk(starts === 1, "area0 muxed starts");
    area0_muxsel_io16_i = 1;
    areas56_card_mode_bit_i = 1;
    @(negedge core_clk_i);
    chk(card_io16_o === 1'b0, "io16 in big endian");
    areas56_card_mode_bit_i = 0;
  endtask

  initial
  begin
    repeat (16) @(posedge core_clk_i);
    @(negedge core_clk_i);
    rst_b_i = 1;
    repeat (2) @(negedge core_clk_i);
    t_straps();
    t_areas();
    t_lanes();
    t_burst_wait();
    t_card();
    t_misc();
    t_rerun();
    wrap_up();
  end

  // run takes about 150 cycles; limit far above
  initial
  begin
    #100000;
    fail_count++;
    wrap_up();
  end
endmodule // test_external_bus_controller

bind external_bus_controller external_bus_controller_asserts u_external_bus_controller_asserts (.*);
